// ### pkg/intc_pkg.sv
// Shared constants and types for the interrupt flag, enable and proximity block
package intc_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam int         ADDR_W         = 8;
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_RELOAD     = 8'h08;
  localparam logic [7:0] OFS_FLAGS      = 8'h0c;
  localparam logic [7:0] OFS_ENABLE     = 8'h10;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h14;
  localparam logic [7:0] OFS_EVT_MASK   = 8'h18;
  localparam logic [7:0] OFS_PRIO_BASE  = 8'h40;
  localparam int         PRIO_REGS      = 8;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int          SRC_N          = 32;
  localparam int          CTL_MULTI_ENTRY_SELECT_BIT   = 12;
  localparam int          CTL_THR_LSB    = 8;
  localparam int          STAT_PRIO_LSB  = 8;
  localparam int          STAT_VEC_LSB   = 0;
  localparam int          PRIO_FLD_LSB   = 2;
  localparam int          SUB_FLD_LSB    = 0;
  localparam int          SRC_PER_REG    = 4;
  localparam logic [31:0] CTL_WMASK      = 32'h0000_1700;
  localparam logic [31:0] PRIO_WMASK     = 32'h1f1f_1f1f;
  localparam int          EVT_PRESENT    = 0;
  localparam int          EVT_PROX_DONE  = 1;
  localparam int          EVT_N          = 2;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic [2:0]  THR_OFF        = 3'h0;
  localparam logic [2:0]  PRIO_OFF       = 3'h0;

  // ------------------------------------------------------------------
  // Bus answers
  // ------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic       valid;
    logic [2:0] prio;
    logic [1:0] sub;
    logic [4:0] src;
  } pick_t;

  typedef struct packed {
    logic [2:0] prio;
    logic [5:0] vector;
  } core_req_t;

endpackage

// ### hdl/source_select.sv
// Picks the highest-priority pending source from the flag and enable banks
`timescale 1ns/1ns
module source_select import intc_pkg::*; (
  input  wire logic [SRC_N-1:0]   pending,
  input  wire logic [SRC_N*3-1:0] prio_vec,
  input  wire logic [SRC_N*2-1:0] sub_vec,
  output pick_t                   best
);

  // Strict compares keep the lowest index on a full tie
  always_comb begin
    logic [2:0] p;
    logic [1:0] s;
    p    = PRIO_OFF;
    s    = 2'h0;
    best = '0;
    for (int i = 0; i < SRC_N; i++) begin
      p = prio_vec[i*3 +: 3];
      s = sub_vec[i*2 +: 2];
      if (pending[i] && p != PRIO_OFF &&
          (!best.valid || p > best.prio || (p == best.prio && s > best.sub))) begin
        best.valid = 1'b1;
        best.prio  = p;
        best.sub   = s;
        best.src   = 5'(i);
      end
    end
  end

endmodule

// ### hdl/proximity_timer.sv
// Down-counting proximity timer, loaded from the reload value on a trigger
`timescale 1ns/1ns
module proximity_timer import intc_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        load,
  input  wire logic [31:0] reload,
  output logic             busy,
  output logic             expired
);

  logic [31:0] count_ff;
  logic        busy_ff;
  logic        expired_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= RST_WORD;
      busy_ff  <= 1'b0;
    end else if (load) begin
      count_ff <= reload;
      busy_ff  <= 1'b1;
    end else if (busy_ff) begin
      if (count_ff == RST_WORD) begin
        busy_ff <= 1'b0;
      end else begin
        count_ff <= count_ff - 32'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= busy_ff && !load && count_ff == RST_WORD;
    end
  end

  assign busy    = busy_ff;
  assign expired = expired_ff;

endmodule

// ### hdl/intc_core.sv
// Interrupt flag, enable, status and proximity timer block on AXI4-Lite
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Function
// - Status records priority of presented interrupt
// - Status records source number of presented interrupt, not the zero single mode vector
// - Unused status bits read as zero
// - Reload value loads proximity timer on trigger
// - Request flags set by sources, software writable
// - Enable bit permits or blocks each source
// - Control bit selects multi or single vector
// - Threshold starts timer at/below priority; zero disables
// - Priority one to seven, zero disables; subpriority
// ------------------------------------------------------------------
module intc_core import intc_pkg::*; (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [SRC_N-1:0]  src_event,
  output logic                   core_req_valid,
  output core_req_t              core_req,
  output logic                   irq
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_prio(input logic [ADDR_W-1:0] a);
    return a[7:5] == OFS_PRIO_BASE[7:5] && {1'b0, a[4:2]} < 4'(PRIO_REGS);
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[7:2], 2'h0};
    return w == OFS_CONTROL || w == OFS_STATUS || w == OFS_RELOAD || w == OFS_FLAGS ||
           w == OFS_ENABLE || w == OFS_EVT_STATUS || w == OFS_EVT_MASK || is_prio(a);
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic              aw_full_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic              w_full_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic              do_write;
  logic [ADDR_W-1:0] waddr;
  logic [31:0]       control_ff;
  logic [2:0]        stat_prio_ff;
  logic [5:0]        stat_vec_ff;
  logic [31:0]       reload_ff;
  logic [31:0]       flags_ff;
  logic [31:0]       nxt_flags;
  logic [31:0]       enable_ff;
  logic [31:0]       prio_reg_ff [PRIO_REGS];
  logic [EVT_N-1:0]  evt_status_ff;
  logic [EVT_N-1:0]  evt_mask_ff;
  logic [EVT_N-1:0]  evt_set;
  logic              req_valid_ff;
  core_req_t         req_ff;
  logic [4:0]        req_src_ff;
  logic [SRC_N*3-1:0] prio_vec;
  logic [SRC_N*2-1:0] sub_vec;
  pick_t             cand;
  logic              multi_entry_select;
  logic [2:0]        thr;
  logic              hold;
  logic              cand_ok;
  logic              new_present;
  logic              tmr_load;
  logic              tmr_busy;
  logic              tmr_expired;
  logic [31:0]       rd_word;

  // ------------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------------
  assign s_axi_awready = !aw_full_ff && !bvalid_ff;
  assign s_axi_wready  = !w_full_ff && !bvalid_ff;
  assign do_write      = aw_full_ff && w_full_ff && !bvalid_ff;
  assign waddr         = {awaddr_ff[7:2], 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      awaddr_ff  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_ff <= 1'b0;
      wdata_ff  <= RST_WORD;
      wstrb_ff  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ------------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;

  always_comb begin
    rd_word = RST_WORD;
    if (is_prio(s_axi_araddr)) begin
      rd_word = prio_reg_ff[s_axi_araddr[4:2]];
    end else begin
      unique case ({s_axi_araddr[7:2], 2'h0})
        OFS_CONTROL:    rd_word = control_ff;
        OFS_STATUS:     rd_word = {21'h0, stat_prio_ff, 2'h0, stat_vec_ff};
        OFS_RELOAD:     rd_word = reload_ff;
        OFS_FLAGS:      rd_word = flags_ff;
        OFS_ENABLE:     rd_word = enable_ff;
        OFS_EVT_STATUS: rd_word = {30'h0, evt_status_ff};
        OFS_EVT_MASK:   rd_word = {30'h0, evt_mask_ff};
        default:        rd_word = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= RST_WORD;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_ff <= RST_WORD;
      reload_ff  <= RST_WORD;
      enable_ff  <= RST_WORD;
    end else if (do_write) begin
      if (waddr == OFS_CONTROL) begin
        control_ff <= merge(control_ff, wdata_ff, wstrb_ff) & CTL_WMASK;
      end
      if (waddr == OFS_RELOAD) begin
        reload_ff <= merge(reload_ff, wdata_ff, wstrb_ff);
      end
      if (waddr == OFS_ENABLE) begin
        enable_ff <= merge(enable_ff, wdata_ff, wstrb_ff);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < PRIO_REGS; k++) begin
        prio_reg_ff[k] <= RST_WORD;
      end
    end else if (do_write && is_prio(awaddr_ff)) begin
      prio_reg_ff[awaddr_ff[4:2]] <= merge(prio_reg_ff[awaddr_ff[4:2]], wdata_ff, wstrb_ff)
                                     & PRIO_WMASK;
    end
  end

  assign multi_entry_select = control_ff[CTL_MULTI_ENTRY_SELECT_BIT];
  assign thr  = control_ff[CTL_THR_LSB +: 3];

  // Sources raise flags on top of any software write so no request is lost
  always_comb begin
    nxt_flags = flags_ff;
    if (do_write && waddr == OFS_FLAGS) begin
      nxt_flags = merge(flags_ff, wdata_ff, wstrb_ff);
    end
    nxt_flags = nxt_flags | src_event;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= RST_WORD;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ------------------------------------------------------------------
  // Source selection and presentation
  // ------------------------------------------------------------------
  always_comb begin
    prio_vec = '0;
    sub_vec  = '0;
    for (int i = 0; i < SRC_N; i++) begin
      prio_vec[i*3 +: 3] = prio_reg_ff[i/SRC_PER_REG][(i%SRC_PER_REG)*8+PRIO_FLD_LSB +: 3];
      sub_vec[i*2 +: 2]  = prio_reg_ff[i/SRC_PER_REG][(i%SRC_PER_REG)*8+SUB_FLD_LSB +: 2];
    end
  end

  source_select u_select (
    .pending  (flags_ff & enable_ff),
    .prio_vec (prio_vec),
    .sub_vec  (sub_vec),
    .best     (cand)
  );

  // A running proximity timer defers sources at or below the threshold
  assign hold        = tmr_busy && thr != THR_OFF && cand.prio <= thr;
  assign cand_ok     = cand.valid && !hold;
  assign new_present = cand_ok && (!req_valid_ff || req_src_ff != cand.src);
  assign tmr_load    = new_present && thr != THR_OFF && cand.prio <= thr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_valid_ff <= 1'b0;
      req_ff       <= '0;
      req_src_ff   <= 5'h0;
    end else begin
      req_valid_ff  <= cand_ok;
      req_src_ff    <= cand.src;
      req_ff.prio   <= cand.prio;
      req_ff.vector <= multi_entry_select ? {1'b0, cand.src} : 6'h00;
    end
  end

  assign core_req_valid = req_valid_ff;
  assign core_req       = req_ff;

  // Hardware capture wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_prio_ff <= PRIO_OFF;
      stat_vec_ff  <= 6'h00;
    end else if (new_present) begin
      stat_prio_ff <= cand.prio;
      stat_vec_ff  <= {1'b0, cand.src};
    end else if (do_write && waddr == OFS_STATUS) begin
      stat_prio_ff <= wstrb_ff[1] ? wdata_ff[STAT_PRIO_LSB +: 3] : stat_prio_ff;
      stat_vec_ff  <= wstrb_ff[0] ? wdata_ff[STAT_VEC_LSB +: 6] : stat_vec_ff;
    end
  end

  proximity_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (tmr_load),
    .reload  (reload_ff),
    .busy    (tmr_busy),
    .expired (tmr_expired)
  );

  // ------------------------------------------------------------------
  // Event status, mask and interrupt line
  // ------------------------------------------------------------------
  assign evt_set = {tmr_expired, new_present};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status_ff <= '0;
    end else if (do_write && waddr == OFS_EVT_STATUS && wstrb_ff[0]) begin
      evt_status_ff <= (evt_status_ff & ~wdata_ff[EVT_N-1:0]) | evt_set;
    end else begin
      evt_status_ff <= evt_status_ff | evt_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_mask_ff <= '0;
    end else if (do_write && waddr == OFS_EVT_MASK && wstrb_ff[0]) begin
      evt_mask_ff <= wdata_ff[EVT_N-1:0];
    end
  end

  assign irq = |(evt_status_ff & evt_mask_ff);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_prio_capture: assert property (new_present |=> stat_prio_ff == $past(cand.prio))
    else $error("status priority not captured");
  chk_vec_capture: assert property (new_present |=> stat_vec_ff == {1'b0, $past(cand.src)})
    else $error("status vector not captured");
  chk_status_zero: assert property (
    s_axi_arvalid && s_axi_arready && {s_axi_araddr[7:2], 2'h0} == OFS_STATUS
    |=> s_axi_rdata[31:11] == 21'h0 && s_axi_rdata[7:6] == 2'h0)
    else $error("status unused bits not zero");
  chk_reload_count: assert property (
    tmr_load && reload_ff == 32'h0000_0002 |=> tmr_busy [*3] ##1 (tmr_expired && !tmr_busy))
    else $error("proximity timer did not run reload cycles");
  chk_flag_sticky: assert property (
    src_event != RST_WORD |=> (flags_ff & $past(src_event)) == $past(src_event))
    else $error("source event lost");
  chk_flag_hold: assert property (
    !(do_write && waddr == OFS_FLAGS) |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
    else $error("flag cleared without software");
  chk_pick_gate: assert property (
    cand.valid |-> enable_ff[cand.src] && flags_ff[cand.src] && cand.prio != PRIO_OFF)
    else $error("blocked source selected");
  chk_single_vec: assert property (
    cand_ok && !multi_entry_select |=> core_req_valid && core_req.vector == 6'h00)
    else $error("single mode vector not zero");
  chk_thr_off: assert property (thr == THR_OFF |-> !tmr_load)
    else $error("proximity timer started while disabled");
  chk_prio_present: assert property (
    core_req_valid |-> core_req.prio != PRIO_OFF ##1 $past(core_req.prio) != PRIO_OFF)
    else $error("zero priority presented");

endmodule

// ### test/core_model.sv
// Processor core model that watches the requests presented by the controller
`timescale 1ns/1ns
module core_model import intc_pkg::*; (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       core_req_valid,
  input  wire core_req_t  core_req,
  output logic [7:0]      seen_cnt_ff,
  output core_req_t       last_req_ff
);
  logic valid_d_ff;

  // Only a rising request counts: the level stands while a source waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_cnt_ff <= 8'h00;
      valid_d_ff  <= 1'b0;
      last_req_ff <= '0;
    end else begin
      valid_d_ff <= core_req_valid;
      if (core_req_valid && !valid_d_ff) begin
        seen_cnt_ff <= seen_cnt_ff + 8'h01;
        last_req_ff <= core_req;
      end
    end
  end
endmodule

// ### test/interrupt_status_enable_proximity_tb.sv
// Self-checking bench for the interrupt flag, enable, status and proximity block
`timescale 1ns/1ns
module interrupt_status_enable_proximity_tb import intc_pkg::*; ;
  logic              aclk;
  logic              aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, core_req_valid, irq;
  logic [SRC_N-1:0]  src_event;
  core_req_t         core_req;
  logic [7:0]        seen_cnt;
  core_req_t         last_req;
  int                failures, compares, cyc, n;

  intc_core DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_event,
    .core_req_valid, .core_req, .irq);

  core_model core (.aclk, .aresetn, .core_req_valid, .core_req,
    .seen_cnt_ff(seen_cnt), .last_req_ff(last_req));

  // ------------------------------------------------------------------
  // Clock, timeout and verdict
  // ------------------------------------------------------------------
  always #2 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Handshakes are judged at the falling edge so the rising edge carries no race
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic at, wt, bt;
    logic [1:0] rs;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    bt = 1'b0;
    while (!bt && n < 100) begin
      @(negedge aclk);
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      bt = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
      n++;
    end
    if (!bt) failures++;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    chk({30'h0, rs}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic at, rt;
    logic [1:0] rs;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    rt = 1'b0;
    while (!rt && n < 100) begin
      @(negedge aclk);
      at = s_axi_arvalid && s_axi_arready;
      rt = s_axi_rvalid;
      rd_q = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (at) s_axi_arvalid <= 1'b0;
      n++;
    end
    if (!rt) failures++;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    chk({30'h0, rs}, {30'h0, er});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    rd(a, er);
    chk(rd_q, ex);
  endtask

  task automatic look(input logic [31:0] ex, input logic [31:0] m);
    @(negedge aclk);
    chk({21'h0, irq, core_req_valid, core_req} & m, ex);
    @(posedge aclk);
  endtask

  function automatic logic [31:0] ov(input logic i, input logic v, input logic [2:0] p,
                                     input logic [5:0] e);
    return {21'h0, i, v, p, e};
  endfunction

  task automatic pulse(input logic [31:0] m);
    src_event <= m;
    @(posedge aclk);
    src_event <= '0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (core_req_valid !== 1'b1 && n < 20);
    if (core_req_valid !== 1'b1) failures++;
    @(posedge aclk);
  endtask

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    src_event = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(OFS_STATUS, RST_WORD, RESP_OKAY);
    rdc(OFS_RELOAD, RST_WORD, RESP_OKAY);
    rdc(OFS_FLAGS, RST_WORD, RESP_OKAY);
    rdc(OFS_ENABLE, RST_WORD, RESP_OKAY);
    look(32'h0, 32'h600);
    rdc(8'hfc, 32'h0, RESP_SLVERR);
    wr(8'hfc, 32'h1234_5678, RESP_SLVERR);
    $display("test reset done");
    wr(OFS_RELOAD, 32'hffff_ffff, RESP_OKAY);
    rdc(OFS_RELOAD, 32'hffff_ffff, RESP_OKAY);
    wr(OFS_STATUS, 32'hffff_ffff, RESP_OKAY);
    rdc(OFS_STATUS, 32'h0000_073f, RESP_OKAY);
    wr(OFS_FLAGS, 32'ha5a5_a5a5, RESP_OKAY);
    rdc(OFS_FLAGS, 32'ha5a5_a5a5, RESP_OKAY);
    wr(OFS_ENABLE, 32'h5a5a_5a5a, RESP_OKAY);
    rdc(OFS_ENABLE, 32'h5a5a_5a5a, RESP_OKAY);
    look(32'h0, 32'h200);
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
    $display("test access done");
    wr(OFS_ENABLE, 32'h0000_00a8, RESP_OKAY);
    wr(OFS_PRIO_BASE, 32'h1400_0000, RESP_OKAY);
    wr(OFS_PRIO_BASE + 8'h04, 32'h0000_1800, RESP_OKAY);
    wr(OFS_EVT_MASK, 32'h1, RESP_OKAY);
    pulse(32'h0000_0088);
    look(ov(1, 1, 5, 0), 32'h7ff);
    rdc(OFS_STATUS, 32'h0000_0503, RESP_OKAY);
    rdc(OFS_FLAGS, 32'h0000_0088, RESP_OKAY);
    rdc(OFS_EVT_STATUS, 32'h1, RESP_OKAY);
    chk({24'h0, seen_cnt}, 32'h1);
    chk({23'h0, last_req}, {23'h0, 3'h5, 6'h00});
    $display("test present done");
    wr(OFS_ENABLE, 32'h0000_0088, RESP_OKAY);
    pulse(32'h0000_0020);
    look(ov(1, 1, 5, 0), 32'h7ff);
    wr(OFS_ENABLE, 32'h0000_00a8, RESP_OKAY);
    look(ov(1, 1, 6, 0), 32'h7ff);
    rdc(OFS_STATUS, 32'h0000_0605, RESP_OKAY);
    wr(OFS_CONTROL, 32'h0000_1000, RESP_OKAY);
    look(ov(1, 1, 6, 5), 32'h7ff);
    wr(OFS_CONTROL, 32'h0, RESP_OKAY);
    wr(OFS_FLAGS, 32'h0000_0080, RESP_OKAY);
    look(32'h0, 32'h200);
    $display("test enable done");
    for (int p = 1; p < 8; p++) begin
      wr(OFS_FLAGS, 32'h0, RESP_OKAY);
      look(32'h0, 32'h200);
      wr(OFS_PRIO_BASE, 32'(p) << 26, RESP_OKAY);
      pulse(32'h0000_0008);
      rdc(OFS_STATUS, (32'(p) << 8) | 32'h3, RESP_OKAY);
    end
    $display("test levels done");
    look(ov(1, 1, 7, 0), 32'h7ff);
    wr(OFS_EVT_MASK, 32'h0, RESP_OKAY);
    look(32'h0, 32'h400);
    wr(OFS_EVT_MASK, 32'h1, RESP_OKAY);
    look(32'h400, 32'h400);
    wr(OFS_EVT_STATUS, 32'h1, RESP_OKAY);
    rdc(OFS_EVT_STATUS, 32'h0, RESP_OKAY);
    look(32'h0, 32'h400);
    $display("test irq done");
    // Short reload so the timer's cycle count check is exercised
    wr(OFS_RELOAD, 32'd2, RESP_OKAY);
    wr(OFS_CONTROL, 32'h0000_0700, RESP_OKAY);
    wr(OFS_EVT_MASK, 32'h2, RESP_OKAY);
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
    pulse(32'h0000_0008);
    rdc(OFS_EVT_STATUS, 32'h1, RESP_OKAY);
    for (int k = 0; k < 30 && rd_q[1] !== 1'b1; k++) rd(OFS_EVT_STATUS, RESP_OKAY);
    chk(rd_q & 32'h2, 32'h2);
    look(32'h400, 32'h400);
    $display("test proximity done");
    wrap_up();
  end
endmodule
